// file: rtl/nvc_ctrl.sv
// data eeprom access controller with ahb-lite register slave
`timescale 1ns/100ps
module nvc_ctrl #(
  parameter int WRITE_CYCLES = nvc_pkg::WRITE_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic write_done_flag,
  output logic write_busy
);
  // ==========================================================
  // storage array and registers
  logic [7:0] mem [0:nvc_pkg::DEPTH-1];
  logic [7:0] addr_low_reg;
  logic [1:0] addr_high_reg;
  logic [7:0] data_reg;
  logic pgd_reg;
  logic config_space_select_reg;
  logic write_enable_bit_reg;
  logic wr_reg;
  logic write_error_flag_reg;
  logic done_reg;
  logic busy_reg;
  logic busy_seen_reg;
  logic [31:0] timer_reg;
  nvc_pkg::nvc_key_e key_reg;
  nvc_pkg::nvc_key_e key_next;
  logic ph_write_reg;
  logic ph_read_reg;
  logic [7:0] ph_ofs_reg;
  logic [31:0] hrdata_reg;
  // ==========================================================
  // ahb-lite address phase decode
  wire addr_phase = hsel && hready && (htrans == nvc_pkg::HTRANS_NONSEQ);
  wire [7:0] a_ofs = haddr[7:0];
  localparam int ADDR_W_L = nvc_pkg::ADDR_W;
  wire [ADDR_W_L-1:0] full_addr;
  assign full_addr = {addr_high_reg, addr_low_reg};
  function automatic logic hit(input logic [7:0] ofs, input logic [7:0] target);
    hit = (ofs == target);
  endfunction
  wire wr_ctl = ph_write_reg && hit(ph_ofs_reg, nvc_pkg::OFS_CONTROL);
  wire wr_key = ph_write_reg && hit(ph_ofs_reg, nvc_pkg::OFS_KEY);
  wire wr_stat = ph_write_reg && hit(ph_ofs_reg, nvc_pkg::OFS_STATUS);
  // lock covers control, address and data while a write runs
  wire locked = busy_reg;
  wire wr_alo = ph_write_reg && hit(ph_ofs_reg, nvc_pkg::OFS_ADDR_LOW) && !locked;
  wire wr_ahi = ph_write_reg && hit(ph_ofs_reg, nvc_pkg::OFS_ADDR_HIGH) && !locked;
  wire wr_dat = ph_write_reg && hit(ph_ofs_reg, nvc_pkg::OFS_DATA) && !locked;
  wire wr_ctl_ok = wr_ctl && !locked;
  wire [7:0] wbyte = hwdata[7:0];
  wire data_space = !wbyte[nvc_pkg::BIT_PGD] && !wbyte[nvc_pkg::BIT_CONFIG_SPACE_SELECT];
  // read starts only on the data space selection in the same write
  wire rd_start = wr_ctl_ok && wbyte[nvc_pkg::BIT_RD] && data_space;
  // enable must already be set, armed key needed
  wire wr_start = wr_ctl_ok && wbyte[nvc_pkg::BIT_WR] && write_enable_bit_reg && data_space
                  && (key_reg == nvc_pkg::KEY_ARMED);
  wire timer_end = busy_reg && (timer_reg == 32'h0000_0001);
  // unlock sequence; any other control or key write breaks it
  always_comb
  begin
    key_next = key_reg;
    if (wr_key)
    begin
      if (wbyte == nvc_pkg::KEY_FIRST)
        key_next = nvc_pkg::KEY_GOT1;
      else if (wbyte == nvc_pkg::KEY_SECOND && key_reg == nvc_pkg::KEY_GOT1)
        key_next = nvc_pkg::KEY_ARMED;
      else
        key_next = nvc_pkg::KEY_IDLE;
    end
    else if (wr_ctl)
      key_next = nvc_pkg::KEY_IDLE;
  end
  // ==========================================================
  // bus phase capture
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ph_write_reg <= 1'b0;
      ph_read_reg <= 1'b0;
      ph_ofs_reg <= nvc_pkg::BYTE_ZERO;
    end
    else
    begin
      ph_write_reg <= addr_phase && hwrite;
      ph_read_reg <= addr_phase && !hwrite;
      ph_ofs_reg <= a_ofs;
    end
  end
  // ==========================================================
  // read mux, registered for the data phase
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (a_ofs)
      nvc_pkg::OFS_ADDR_LOW: rd_mux[7:0] = addr_low_reg;
      nvc_pkg::OFS_ADDR_HIGH: rd_mux[1:0] = addr_high_reg;
      nvc_pkg::OFS_DATA: rd_mux[7:0] = data_reg;
      nvc_pkg::OFS_CONTROL:
      begin
        rd_mux[nvc_pkg::BIT_PGD] = pgd_reg;
        rd_mux[nvc_pkg::BIT_CONFIG_SPACE_SELECT] = config_space_select_reg;
        rd_mux[nvc_pkg::BIT_WRITE_ERROR_FLAG] = write_error_flag_reg;
        rd_mux[nvc_pkg::BIT_WRITE_ENABLE_BIT] = write_enable_bit_reg;
        rd_mux[nvc_pkg::BIT_WR] = wr_reg;
      end
      nvc_pkg::OFS_STATUS: rd_mux[nvc_pkg::BIT_DONE] = done_reg;
      default: rd_mux = 32'h0000_0000; // key reads zero
    endcase
  end
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      hrdata_reg <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
      hrdata_reg <= rd_mux;
  end
  // ==========================================================
  // control, address and data registers
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      key_reg <= nvc_pkg::KEY_IDLE;
      pgd_reg <= 1'b0;
      config_space_select_reg <= 1'b0;
      write_enable_bit_reg <= 1'b0;
      addr_low_reg <= nvc_pkg::BYTE_ZERO;
      addr_high_reg <= 2'b00;
      data_reg <= nvc_pkg::BYTE_ZERO;
    end
    else
    begin
      key_reg <= key_next;
      if (wr_ctl_ok)
      begin
        pgd_reg <= wbyte[nvc_pkg::BIT_PGD];
        config_space_select_reg <= wbyte[nvc_pkg::BIT_CONFIG_SPACE_SELECT];
        write_enable_bit_reg <= wbyte[nvc_pkg::BIT_WRITE_ENABLE_BIT]; // only software changes it
      end
      if (wr_alo)
        addr_low_reg <= wbyte;
      if (wr_ahi)
        addr_high_reg <= wbyte[1:0];
      // read data ready for any bus access not back-to-back with this control write
      if (rd_start)
        data_reg <= mem[full_addr];
      else if (wr_dat)
        data_reg <= wbyte;
    end
  end
  // ==========================================================
  // self-timed write engine
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_reg <= 1'b0;
      busy_reg <= 1'b0;
      timer_reg <= 32'h0000_0000;
      done_reg <= 1'b0;
    end
    else
    begin
      if (wr_start)
      begin
        wr_reg <= 1'b1; // set-only from software
        busy_reg <= 1'b1;
        timer_reg <= WRITE_CYCLES;
      end
      else if (timer_end)
      begin
        wr_reg <= 1'b0;
        busy_reg <= 1'b0;
        timer_reg <= 32'h0000_0000;
      end
      else if (busy_reg)
        timer_reg <= timer_reg - 32'h0000_0001;
      // completion sets even if software clears in the same cycle
      if (timer_end)
        done_reg <= 1'b1;
      else if (wr_stat && wbyte[nvc_pkg::BIT_DONE])
        done_reg <= 1'b0;
    end
  end
  // array update at end of the timed cycle, from the data loaded before unlock
  always_ff @(posedge core_clk)
  begin
    if (timer_end)
      mem[full_addr] <= data_reg;
  end
  // error flag survives the reset that aborted a write
  // busy_reg clears at once on reset, so an unreset copy from the last edge
  // remembers that a write was running when reset struck
  always_ff @(posedge core_clk)
  begin
    busy_seen_reg <= busy_reg;
    if (reset)
      write_error_flag_reg <= busy_seen_reg | write_error_flag_reg;
    else if (wr_start)
      write_error_flag_reg <= 1'b0;
    else if (wr_ctl_ok)
      write_error_flag_reg <= wbyte[nvc_pkg::BIT_WRITE_ERROR_FLAG] & write_error_flag_reg;
  end
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign write_done_flag = done_reg;
  assign write_busy = busy_reg;
endmodule

// file: shared/nvc_pkg.sv
// package: register map, bit positions, unlock keys and timing for the data eeprom controller
// Overview of operation
// - read happens when address loaded, bits 7 and 6 clear, bit 0 set
// - read data lands in the data register in time for any access not back-to-back with the control write
// - data register keeps read value until next read or software write
// - software loads address and data before starting the unlock sequence
// - write starts only after key writes 55h then AAh then write-start
// - a write cycle is allowed only while write enable is set
// - hardware never clears write enable, even after a write finishes
// - during a write, control, both address and data registers are locked
// - write-start cannot be set unless write enable is already set
// - one write setting both enable and start does not start a write
// - at write end hardware clears write-start and sets the done flag
// - done flag is cleared only by software
// - read-start and write-start are set-only; hardware clears them
// - reset during a write sets error flag and zeroes address and data
// - address is 10 bits; high register upper six bits read zero
// - key register has no storage, reads zero, writes feed unlock sequence
package nvc_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_ADDR_LOW = 8'h00;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_KEY = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // ==========================================================
  // control register bits
  localparam int BIT_RD = 0;
  localparam int BIT_WR = 1;
  localparam int BIT_WRITE_ENABLE_BIT = 2;
  localparam int BIT_WRITE_ERROR_FLAG = 3;
  localparam int BIT_CONFIG_SPACE_SELECT = 6;
  localparam int BIT_PGD = 7;
  // status register bit
  localparam int BIT_DONE = 0;
  // ==========================================================
  localparam int ADDR_W = 10;
  localparam int DEPTH = 1024;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // self-timed write duration in microseconds and derived cycles at 200 MHz
  localparam int WRITE_TIME_US = 4000;
  localparam int CLK_MHZ = 200;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_ARMED} nvc_key_e;
endpackage

// file: tb/nvc_ctrl_properties.sv
// checker: bus and write-cycle properties of the eeprom controller
`timescale 1ns/100ps
module nvc_props #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic write_done_flag,
  input wire logic write_busy
);
  // ==========================================================
  // data-phase tracking
  logic ph_reg;
  logic w_reg;
  logic [7:0] a_reg;
  wire take = hsel && hready && htrans == nvc_pkg::HTRANS_NONSEQ;
  wire ctl_w = ph_reg && w_reg && a_reg == nvc_pkg::OFS_CONTROL;
  wire st_w = ph_reg && w_reg && a_reg == nvc_pkg::OFS_STATUS;
  wire key_r = ph_reg && !w_reg && a_reg == nvc_pkg::OFS_KEY;
  wire ah_r = ph_reg && !w_reg && a_reg == nvc_pkg::OFS_ADDR_HIGH;
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      ph_reg <= 1'b0;
    else
      ph_reg <= take;
  // no reset: only looked at while ph_reg is high
  always_ff @(posedge core_clk)
    if (take)
    begin
      a_reg <= haddr[7:0];
      w_reg <= hwrite;
    end
  // ==========================================================
  // properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  chk_start_cause: assert property ($rose(write_busy) |-> $past(ctl_w) && $past(hwdata[1]))
    else $error("write began without a write-start");
  chk_busy_hold: assert property ($rose(write_busy) |-> write_busy [*8])
    else $error("write-start dropped early");
  chk_busy_end: assert property ($rose(write_busy) |-> ##[1:60] !write_busy)
    else $error("write never finished");
  chk_done_set: assert property ($fell(write_busy) |-> ##[0:1] write_done_flag)
    else $error("done flag not set at write end");
  chk_done_cause: assert property ($rose(write_done_flag) |-> $past(write_busy) || $past(write_busy, 2))
    else $error("done flag rose with no write");
  chk_done_keep: assert property (write_done_flag && !st_w |=> write_done_flag)
    else $error("done flag cleared by itself");
  chk_key_zero: assert property (key_r |-> hrdata == 32'h0000_0000)
    else $error("key read not zero");
  chk_ahigh_zero: assert property (ah_r |-> (hrdata & 32'hffff_fffc) == 32'h0000_0000)
    else $error("high address upper bits not zero");
  cover property ($rose(write_busy));
  cover property ($fell(write_busy));
  cover property (key_r);
endmodule

// file: tb/tb.sv
// testbench: random and corner-case register traffic for the eeprom controller
`timescale 1ns/100ps
module tb;
  // ==========================================================
  // signals and design
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic hrdy;
  logic done;
  logic busy;
  logic [9:0] ad;
  logic [7:0] dt;
  int n_fail = 0;
  int n_compared = 0;
  int seed = 32'h91f4_6597;
  // packed as pre-control, key one, key two, final control
  logic [31:0] bad [7] = '{32'h0055_aa06, 32'h04aa_5506, 32'h0455_0006, 32'h0455_aa86,
    32'h0455_aa46, 32'h0400_0006, 32'h0055_aa02};
  nvc_ctrl #(.WRITE_CYCLES(20)) u_dut (.core_clk(core_clk), .reset(reset), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(),
    .write_done_flag(done), .write_busy(busy));
  initial
    forever #2.5 core_clk = ~core_clk;
  // ==========================================================
  // bus tasks
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    haddr <= {24'h00_0000, a};
    htrans <= nvc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge core_clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge core_clk); while (hrdy !== 1'b1);
    q = hrdata;
    // let the edge's updates settle before callers look at the outputs
    @(negedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    chk($sformatf("reg %h", a), q & m, {24'h00_0000, e});
  endtask
  // the bench has no interrupt source, so the unlock runs unbroken
  task automatic start(input logic [31:0] s);
    xfer(nvc_pkg::OFS_CONTROL, 1'b1, s[31:24]);
    xfer(nvc_pkg::OFS_KEY, 1'b1, s[23:16]);
    xfer(nvc_pkg::OFS_KEY, 1'b1, s[15:8]);
    xfer(nvc_pkg::OFS_CONTROL, 1'b1, s[7:0]);
  endtask
  task automatic summarize;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++)
      rc(8'(i * 4), 32'hffff_fff7, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      ad = (i == 0) ? 10'h3ff : 10'($random(seed));
      dt = 8'($random(seed));
      xfer(nvc_pkg::OFS_ADDR_LOW, 1'b1, ad[7:0]);
      xfer(nvc_pkg::OFS_ADDR_HIGH, 1'b1, {6'h3f, ad[9:8]});
      xfer(nvc_pkg::OFS_DATA, 1'b1, dt);
      start(32'h0455_aa06);
      chk("busy", busy, 1'b1);
      xfer(nvc_pkg::OFS_DATA, 1'b1, ~dt);
      xfer(nvc_pkg::OFS_ADDR_LOW, 1'b1, ~ad[7:0]);
      xfer(nvc_pkg::OFS_CONTROL, 1'b1, 8'h00);
      rc(nvc_pkg::OFS_DATA, 32'hffff_ffff, dt);
      rc(nvc_pkg::OFS_ADDR_LOW, 32'hffff_ffff, ad[7:0]);
      while (busy === 1'b1)
        @(posedge core_clk);
      rc(nvc_pkg::OFS_CONTROL, 32'hffff_fff7, 8'h04);
      rc(nvc_pkg::OFS_ADDR_HIGH, 32'hffff_ffff, {6'h00, ad[9:8]});
      chk("done", done, 1'b1);
      xfer(nvc_pkg::OFS_STATUS, 1'b1, 8'h01);
      chk("done clear", done, 1'b0);
      xfer(nvc_pkg::OFS_DATA, 1'b1, 8'h00);
      // enable dropped once the update is over
      xfer(nvc_pkg::OFS_CONTROL, 1'b1, 8'h01);
      rc(nvc_pkg::OFS_DATA, 32'hffff_ffff, dt);
      rc(nvc_pkg::OFS_KEY, 32'hffff_ffff, 8'h00);
      rc(nvc_pkg::OFS_DATA, 32'hffff_ffff, dt);
    end
    foreach (bad[j])
    begin
      start(bad[j]);
      chk("refused", busy, 1'b0);
    end
    xfer(nvc_pkg::OFS_DATA, 1'b1, 8'h5a);
    start(32'h0455_aa06);
    repeat (5) @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rc(nvc_pkg::OFS_CONTROL, 32'h0000_0008, 8'h08);
    rc(nvc_pkg::OFS_DATA, 32'hffff_ffff, 8'h00);
    rc(nvc_pkg::OFS_ADDR_LOW, 32'hffff_ffff, 8'h00);
    summarize();
  end
  // hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    #50000;
    n_fail++;
    summarize();
  end
endmodule
bind nvc_ctrl nvc_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (.core_clk, .reset, .hsel,
  .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .write_done_flag, .write_busy);
